// *** mfm_chk_sva.sv ***
/*
  Codec port checker: pulse lengths, gating, loop selection.
  Bound by the bench; assumes 128 pclk per byte.
*/
`timescale 1ns/1ps
`default_nettype none
module mfm_chk #(
  parameter int B = 128 // pclk cycles per byte
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic write_gate_sel_n,
  input wire logic read_out_gate_n,
  input wire logic return_to_zero,
  input wire logic mfm_write_pulse,
  input wire logic loop_squelch_n,
  input wire logic servo_input_select,
  input wire logic freq_down_req,
  input wire logic freq_up_req,
  input wire logic bit_window,
  input wire logic separated_bit,
  input wire logic nrz_read_out,
  input wire logic fast_sync_n,
  input wire logic gap_count_n,
  input wire logic mark_found,
  input wire logic no_squelch_gate
);
  logic [11:0] f_q; // cycles with fast-sync low
  logic [11:0] g_q; // cycles with gap-count low
  logic [11:0] m_q; // cycles with mark-found high
  // pulse length counters
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      f_q <= '0;
      g_q <= '0;
      m_q <= '0;
    end
    else
    begin
      f_q <= fast_sync_n ? '0 : f_q + 1'b1;
      g_q <= gap_count_n ? '0 : g_q + 1'b1;
      m_q <= mark_found ? m_q + 1'b1 : '0;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_fast_len: assert property (
    $rose(fast_sync_n) |-> f_q inside {[5*B:6*B+4], [14*B:15*B+4]})
    else $error("fast-sync length wrong");
  a_gap_follows: assert property (
    $rose(fast_sync_n) |-> ##[0:2] !gap_count_n)
    else $error("gap-count did not follow fast-sync");
  a_gap_len: assert property (
    $rose(gap_count_n) |-> g_q inside {[B-4:B+4]})
    else $error("gap-count length wrong");
  a_mark_len: assert property (
    $fell(mark_found) |-> m_q inside {[7*B:8*B+4]})
    else $error("mark-found length wrong");
  a_servo_set: assert property (
    $rose(fast_sync_n) && read_out_gate_n |-> ##[0:3] servo_input_select)
    else $error("servo select not set after fast-sync");
  a_read_servo: assert property (
    (loop_squelch_n && !read_out_gate_n) [*6] |-> !servo_input_select)
    else $error("servo select held during read");
  a_rtz_squelch: assert property (
    return_to_zero [*6] |-> !loop_squelch_n)
    else $error("loop not squelched");
  a_out_gated: assert property (
    read_out_gate_n [*6] |-> !nrz_read_out)
    else $error("read output not held clear");
  a_sep_window: assert property (
    $rose(separated_bit) |-> $past(bit_window))
    else $error("separated bit set outside window");
  a_freq_excl: assert property (
    !(freq_down_req && freq_up_req))
    else $error("both frequency requests");
  a_idle_write: assert property (
    write_gate_sel_n [*6] |-> !mfm_write_pulse)
    else $error("write pulse without write gate");
  a_nsq_write: assert property (
    !write_gate_sel_n [*6] |-> !no_squelch_gate)
    else $error("no-squelch gate while writing");
endmodule : mfm_chk
`default_nettype wire

// *** mfm_codec_cfg.svh ***
/*
  Numeric constants of the MFM codec: offsets, fields, timing counts.
  Assumes a 200 MHz pclk and inclusion by bare name.
*/
`ifndef MFM_CODEC_CFG_SVH
`define MFM_CODEC_CFG_SVH

// clock and analogue-side timing
`define CLK_PERIOD_NS    5
`define NSQ_DELAY_NS     2000
`define NSQ_CYCLES       ((`NSQ_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NSQ_CNT_W        9

// byte timing in recovered 2F periods
`define CELLS_PER_BYTE   16
`define CELL_CNT_W       4
`define BYTE_CNT_W       4
`define INIT_FAST_BYTES  15
`define READ_FAST_BYTES  6
`define READ_DELAY_BYTES 7
`define GAP_BYTES        1
`define MARK_BYTES       8

// apb register offsets (byte addresses)
`define REG_CTRL         12'h000
`define REG_STATUS       12'h004
`define REG_EVENTS       12'h008

// control register fields and reset value
`define CTRL_VAR_BIT     0
`define CTRL_WEN_BIT     1
`define CTRL_W           2
`define CTRL_RESET       2'h2

// event counter width
`define EVT_W            16

// synchronised pin indices
`define PIN_WCLK   0
`define PIN_WDATA  1
`define PIN_WGATE  2
`define PIN_RCLK   3
`define PIN_MCLK   4
`define PIN_TIMED  5
`define PIN_DLYRD  6
`define PIN_E1     7
`define PIN_E2     8
`define PIN_OT     9
`define PIN_LT     10
`define PIN_RGC    11
`define PIN_RDGATE 12
`define PIN_SEEK   13
`define PIN_RTZ    14
`define PIN_MARK   15
`define PIN_SEARCH 16
`define PIN_SERVO  17
`define PIN_RAW    18
`define PIN_COUNT  19

`endif

// *** mfm_codec_pkg.sv ***
/*
  Types of the MFM codec: sequencer states, tap choice, status word.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package mfm_codec_pkg;

  // loop start-up / read sequencer
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_DELAY,
    SEQ_FAST,
    SEQ_GAP
  } seq_state_t;

  // one-hot choice of precompensation tap
  typedef struct packed {
    logic early1;
    logic early2;
    logic nominal;
    logic late;
  } phase_sel_t;

  // status register layout, low bits
  typedef struct packed {
    logic [22:0] zero;
    logic [1:0]  seq;
    logic        servo_latch;
    logic        servo_sel;
    logic        squelch;
    logic        fast;
    logic        gap;
    logic        mark;
    logic        writing;
  } status_t;

endpackage : mfm_codec_pkg
`default_nettype wire

// *** mfm_codec_vfo_sequencer.sv ***
/*
  MFM write encoder with four-tap precompensation, read data separator,
  loop input gating and fast-sync / gap-count sequencer, with APB access.
  Assumes loop signals arrive as pins sampled on pclk
  and a controller holding read gate control low a byte.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfm_codec_cfg.svh"
module mfm_codec_vfo_sequencer
  import mfm_codec_pkg::*;
(
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic        [31:0] prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire  logic        host_write_clock,
  input  wire  logic        nrz_write_in,
  input  wire  logic        write_gate_sel_n,
  input  wire  logic        recovered_double_clock,
  input  wire  logic        main_double_clock_n,
  input  wire  logic        phase_early_one,
  input  wire  logic        phase_early_two,
  input  wire  logic        phase_nominal,
  input  wire  logic        phase_late,
  input  wire  logic        timed_data_input,
  input  wire  logic        delayed_read_pulse,
  input  wire  logic        servo_ref_clock,
  input  wire  logic        raw_read_pulses,
  input  wire  logic        read_gate_ctrl,
  input  wire  logic        read_out_gate_n,
  input  wire  logic        seek_done,
  input  wire  logic        return_to_zero,
  input  wire  logic        mark_detected,
  input  wire  logic        mark_search_req,
  output logic               mfm_write_pulse,
  output logic               loop_input,
  output logic               loop_squelch_n,
  output logic               servo_input_select,
  output logic               freq_down_req,
  output logic               freq_up_req,
  output logic               pre_window,
  output logic               bit_window,
  output logic               half_rate_read_clock,
  output logic               separated_bit,
  output logic               clear_pulse_normal,
  output logic               clear_pulse_gap,
  output logic               nrz_read_out,
  output logic               fast_sync_n,
  output logic               gap_count_n,
  output logic               mark_found,
  output logic               no_squelch_gate
);

  logic [`PIN_COUNT-1:0] lv;          // filtered pin levels
  logic [`PIN_COUNT-1:0] rs;          // rising edge pulses
  logic [`PIN_COUNT-1:0] fl;          // falling edge pulses

  // all pins through three-flop sync
  pin_sync #(
    .W (`PIN_COUNT)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({raw_read_pulses, servo_ref_clock, mark_search_req,
               mark_detected, return_to_zero, seek_done,
               read_out_gate_n, read_gate_ctrl, phase_late,
               phase_nominal, phase_early_two, phase_early_one,
               delayed_read_pulse, timed_data_input, main_double_clock_n,
               recovered_double_clock, write_gate_sel_n, nrz_write_in,
               host_write_clock}),
    .level   (lv),
    .rise    (rs),
    .fall    (fl)
  );

  logic [`CTRL_W-1:0]     ctrl_q;      // format and write enable
  logic                   cell_q;      // 0 clock cell, 1 data cell
  logic [`CELL_CNT_W-1:0] cell_cnt_q;  // periods within a byte
  logic                   byte_tick;   // one byte time elapsed
  logic                   bit_tick;    // start of a new bit
  logic                   captured_q;  // bit taken from host
  logic                   writing_q;   // write resync armed
  logic [3:0]             sr_q;        // bit 0 newest stage
  phase_sel_t             data_sel;    // tap for data cell
  phase_sel_t             clk_sel;     // tap for clock cell
  phase_sel_t             sel;         // tap for current cell
  logic                   tap_edge;    // selected tap rising
  logic                   servo_latch_q;
  logic                   squelch;
  logic                   reading;
  logic                   clear_gap;
  logic                   win_close;
  seq_state_t             seq_q;
  logic [`BYTE_CNT_W-1:0] seq_cnt_q;   // bytes spent in state
  logic [`BYTE_CNT_W-1:0] fast_len_q;  // fast-sync length
  logic                   latch_d_q;   // servo latch delayed
  logic                   fs_end;
  logic [`BYTE_CNT_W-1:0] mark_cnt_q;
  logic [`NSQ_CNT_W-1:0]  nsq_cnt_q;
  logic [`EVT_W-1:0]      up_cnt_q;
  logic [`EVT_W-1:0]      down_cnt_q;
  status_t                status;

  // cell phase and byte count per clock rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cell_q     <= 1'b0;
      cell_cnt_q <= '0;
    end
    else if (rs[`PIN_RCLK])
    begin
      cell_q     <= ~cell_q;
      cell_cnt_q <= cell_cnt_q + 1'b1;
    end
  end

  assign bit_tick  = rs[`PIN_RCLK] && cell_q;
  assign byte_tick = rs[`PIN_RCLK] &&
                     (cell_cnt_q == `CELL_CNT_W'(`CELLS_PER_BYTE - 1));

  // host write bit capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      captured_q <= 1'b0;
    else if (rs[`PIN_WCLK])
      captured_q <= lv[`PIN_WDATA];
  end

  // resync armed at gate fall, shifts per bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      writing_q <= 1'b0;
      sr_q      <= '0;
    end
    else
    begin
      if (fl[`PIN_WGATE] && ctrl_q[`CTRL_WEN_BIT])
        writing_q <= 1'b1;
      else if (lv[`PIN_WGATE])
        writing_q <= 1'b0;
      if (writing_q && bit_tick)
        sr_q <= {sr_q[2:0], captured_q};
      else if (!writing_q)
        sr_q <= '0;
    end
  end

  // encoder table; stage 3 unused for data
  always_comb
  begin
    data_sel = '0;
    clk_sel  = '0;
    if (sr_q[1])
    begin
      data_sel.early1  = !sr_q[0] && sr_q[2];
      data_sel.early2  = !sr_q[0] && !sr_q[2];
      data_sel.nominal = sr_q[0] && sr_q[2];
      data_sel.late    = sr_q[0] && !sr_q[2];
    end
    else if (!sr_q[2])
    begin
      clk_sel.early1  = sr_q[0] && !sr_q[3];
      clk_sel.early2  = sr_q[0] && sr_q[3];
      clk_sel.nominal = !sr_q[0] && !sr_q[3];
      clk_sel.late    = !sr_q[0] && sr_q[3];
    end
    // other states: no tap
    sel = cell_q ? data_sel : clk_sel;
  end

  assign tap_edge = (sel.early1  && rs[`PIN_E1]) ||
                    (sel.early2  && rs[`PIN_E2]) ||
                    (sel.nominal && rs[`PIN_OT]) ||
                    (sel.late    && rs[`PIN_LT]);

  // precompensated write pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mfm_write_pulse <= 1'b0;
    else
      mfm_write_pulse <= writing_q && tap_edge;
  end

  // servo latch: seek sets, return-to-zero clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      servo_latch_q <= 1'b0;
    else if (rs[`PIN_SEEK])
      servo_latch_q <= 1'b1;
    else if (lv[`PIN_RTZ])
      servo_latch_q <= 1'b0;
  end

  assign squelch = lv[`PIN_RTZ] || !servo_latch_q;
  assign reading = !lv[`PIN_RDGATE] && servo_latch_q;

  // servo select set at fast-sync end, dropped during reads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      servo_input_select <= 1'b0;
    else if (reading)
      servo_input_select <= 1'b0;
    else if (fs_end)
      servo_input_select <= 1'b1;
  end

  // switching gate into the loop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loop_input     <= 1'b0;
      loop_squelch_n <= 1'b0;
    end
    else
    begin
      loop_squelch_n <= !squelch;
      if (squelch)
        loop_input <= 1'b0;
      else if (servo_input_select)
        loop_input <= lv[`PIN_SERVO];
      else
        loop_input <= lv[`PIN_RAW];
    end
  end

  // phase latch and lead / lag requests
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_down_req <= 1'b0;
      freq_up_req   <= 1'b0;
    end
    else
    begin
      freq_down_req <= rs[`PIN_TIMED] && !lv[`PIN_RCLK];
      freq_up_req   <= rs[`PIN_TIMED] && lv[`PIN_RCLK];
    end
  end

  logic phase_latch_q;  // set by input, cleared by clock fall
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_latch_q <= 1'b0;
    else if (rs[`PIN_TIMED])
      phase_latch_q <= 1'b1;
    else if (fl[`PIN_RCLK])
      phase_latch_q <= 1'b0;
  end

  assign clear_gap = !gap_count_n && separated_bit;
  assign win_close = rs[`PIN_MCLK] && bit_window && !pre_window;

  // window divider; gap one flips both
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_window <= 1'b0;
      bit_window <= 1'b0;
    end
    else if (clear_gap)
    begin
      pre_window <= !pre_window;
      bit_window <= !bit_window;
    end
    else if (rs[`PIN_MCLK])
    begin
      pre_window <= !pre_window;
      bit_window <= pre_window;
    end
  end

  assign half_rate_read_clock = bit_window;

  // separated bit and its two clear pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      separated_bit      <= 1'b0;
      clear_pulse_normal <= 1'b0;
      clear_pulse_gap    <= 1'b0;
    end
    else
    begin
      clear_pulse_normal <= win_close && gap_count_n;
      clear_pulse_gap    <= clear_gap;
      if (rs[`PIN_DLYRD] && bit_window)
        separated_bit <= 1'b1;
      else if ((win_close && gap_count_n) || clear_gap)
        separated_bit <= 1'b0;
    end
  end

  // read output loaded at window close
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nrz_read_out <= 1'b0;
    else if (lv[`PIN_RDGATE])
      nrz_read_out <= 1'b0;
    else if (win_close)
      nrz_read_out <= separated_bit;
  end

  // mark found pulse for variable format
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mark_found <= 1'b0;
      mark_cnt_q <= '0;
    end
    else if (!mark_found)
    begin
      mark_cnt_q <= '0;
      if (rs[`PIN_MARK] && lv[`PIN_SEARCH] && ctrl_q[`CTRL_VAR_BIT])
        mark_found <= 1'b1;
    end
    else if (byte_tick)
    begin
      mark_cnt_q <= mark_cnt_q + 1'b1;
      if (mark_cnt_q == `BYTE_CNT_W'(`MARK_BYTES - 1))
        mark_found <= 1'b0;
    end
  end

  // sequencer triggers
  logic start_init;
  logic start_read;
  assign start_init = servo_latch_q && !latch_d_q;
  assign start_read = ctrl_q[`CTRL_VAR_BIT] ?
                      (rs[`PIN_MARK] && lv[`PIN_SEARCH] && !mark_found) :
                      fl[`PIN_RGC];

  // fast-sync / gap-count sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_q       <= SEQ_IDLE;
      seq_cnt_q   <= '0;
      fast_len_q  <= '0;
      latch_d_q   <= 1'b0;
      fast_sync_n <= 1'b1;
      gap_count_n <= 1'b1;
      fs_end      <= 1'b0;
    end
    else
    begin
      latch_d_q <= servo_latch_q;
      fs_end    <= 1'b0;
      case (seq_q)
        SEQ_IDLE:
        begin
          seq_cnt_q <= '0;
          if (start_init)
          begin
            seq_q       <= SEQ_FAST;
            fast_len_q  <= `BYTE_CNT_W'(`INIT_FAST_BYTES);
            fast_sync_n <= 1'b0;
          end
          else if (start_read && servo_latch_q)
          begin
            seq_q      <= SEQ_DELAY;
            fast_len_q <= `BYTE_CNT_W'(`READ_FAST_BYTES);
          end
        end
        SEQ_DELAY:
          if (byte_tick)
          begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
            if (seq_cnt_q == `BYTE_CNT_W'(`READ_DELAY_BYTES - 1))
            begin
              seq_q       <= SEQ_FAST;
              seq_cnt_q   <= '0;
              fast_sync_n <= 1'b0;
            end
          end
        SEQ_FAST:
          if (byte_tick)
          begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
            if (seq_cnt_q == fast_len_q - 1'b1)
            begin
              seq_q       <= SEQ_GAP;
              seq_cnt_q   <= '0;
              fast_sync_n <= 1'b1;
              gap_count_n <= 1'b0;
              fs_end      <= 1'b1;
            end
          end
        SEQ_GAP:
          if (byte_tick)
          begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
            if (seq_cnt_q == `BYTE_CNT_W'(`GAP_BYTES - 1))
            begin
              seq_q       <= SEQ_IDLE;
              seq_cnt_q   <= '0;
              gap_count_n <= 1'b1;
            end
          end
        default:
        begin
          seq_q       <= SEQ_IDLE;
          fast_sync_n <= 1'b1;
          gap_count_n <= 1'b1;
        end
      endcase
    end
  end

  // no-squelch gate after write gate deasserts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nsq_cnt_q       <= '0;
      no_squelch_gate <= 1'b0;
    end
    else if (!lv[`PIN_WGATE])
    begin
      nsq_cnt_q       <= '0;
      no_squelch_gate <= 1'b0;
    end
    else if (nsq_cnt_q == `NSQ_CNT_W'(`NSQ_CYCLES - 1))
      no_squelch_gate <= 1'b1;
    else
      nsq_cnt_q <= nsq_cnt_q + 1'b1;
  end

  // loop request event counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_cnt_q   <= '0;
      down_cnt_q <= '0;
    end
    else
    begin
      if (freq_up_req)
        up_cnt_q <= up_cnt_q + 1'b1;
      if (freq_down_req)
        down_cnt_q <= down_cnt_q + 1'b1;
    end
  end

  // status word
  always_comb
  begin
    status             = '0;
    status.seq         = seq_q;
    status.servo_latch = servo_latch_q;
    status.servo_sel   = servo_input_select;
    status.squelch     = squelch;
    status.fast        = !fast_sync_n;
    status.gap         = !gap_count_n;
    status.mark        = mark_found;
    status.writing     = writing_q;
  end

  logic apb_wr;  // write access phase
  logic apb_rd;  // read access phase
  logic mapped;  // address decodes
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  assign mapped  = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
                   (paddr == `REG_EVENTS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // control register write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= `CTRL_RESET;
    else if (apb_wr && paddr == `REG_CTRL)
      ctrl_q <= pwdata[`CTRL_W-1:0];
  end

  // read data loaded in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      case (paddr)
        `REG_CTRL:   prdata <= {{(32-`CTRL_W){1'b0}}, ctrl_q};
        `REG_STATUS: prdata <= status;
        `REG_EVENTS: prdata <= {up_cnt_q, down_cnt_q};
        default:     prdata <= '0;
      endcase
  end

endmodule : mfm_codec_vfo_sequencer
`default_nettype wire

// *** mfm_codec_vfo_sequencer_test.sv ***
/*
  Codec bench: APB, sequencer timing, write and read paths.
  Assumes the checker and controller model compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %0t %h %h", $time, a, e); end end
module mfm_codec_vfo_sequencer_test;
  localparam int B = 128; // 16 recovered periods of 8 pclk
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic host_write_clock, nrz_write_in, write_gate_sel_n, err, rd_on;
  logic recovered_double_clock, main_double_clock_n, timed_data_input;
  logic phase_early_one, phase_early_two, phase_nominal, phase_late;
  logic delayed_read_pulse, servo_ref_clock, raw_read_pulses, loop_input;
  logic read_gate_ctrl, read_out_gate_n, seek_done, return_to_zero;
  logic mark_detected, mark_search_req, mfm_write_pulse, pre_window;
  logic loop_squelch_n, servo_input_select, freq_down_req, freq_up_req;
  logic bit_window, half_rate_read_clock, separated_bit, nrz_read_out;
  logic clear_pulse_normal, clear_pulse_gap, fast_sync_n, gap_count_n;
  logic mark_found, no_squelch_gate;
  logic [3:0]  ph, tap;
  logic [1:0]  pat;
  int          n_mismatch, compares, n;
  logic [1:0]  pt [4] = '{2'h1, 2'h2, 2'h2, 2'h0}; // data pattern
  logic [3:0]  tm [4] = '{4'h2, 4'h2, 4'h4, 4'h2}; // live taps
  int          lo [4] = '{60, 0, 29, 60};
  int          hi [4] = '{68, 0, 35, 68};
  mfm_codec_vfo_sequencer mfm_codec_vfo_sequencer_inst (.*);
  mfm_host_model mfm_host_model_inst (.*);
  // system clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // loop-side clocks, taps and read pulses
  always @(posedge pclk)
  begin
    ph <= ph + 4'h1;
    recovered_double_clock <= ph[2];
    main_double_clock_n <= ph[2];
    servo_ref_clock <= ph[3];
    {phase_early_one, phase_early_two, phase_nominal, phase_late}
      <= {4{ph[2]}} & tap;
    delayed_read_pulse <= rd_on && ph[2:1] == 2'h1;
    raw_read_pulses <= rd_on && ph[2:1] == 2'h1;
    timed_data_input <= rd_on && ph[2:1] == 2'h1;
  end
  task end_sim;
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wt(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 4000)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK(s, v)
  endtask : wt
  task t_regs;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h0000_0002)
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h0000_0003)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1'b1, 12'h000, 32'h0000_0002);
  endtask : t_regs
  task t_tail;
    wt(gap_count_n, 1'b0);
    wt(gap_count_n, 1'b1);
    `CHK(n inside {[B-8:B+4]}, 1'b1)
  endtask : t_tail
  task t_start;
    seek_done <= 1'b1;
    wt(fast_sync_n, 1'b0);
    `CHK(loop_squelch_n, 1'b1)
    wt(fast_sync_n, 1'b1);
    `CHK(n inside {[14*B-4:15*B+4]}, 1'b1)
    t_tail();
    `CHK(servo_input_select, 1'b1)
  endtask : t_start
  task t_fixed;
    read_gate_ctrl <= 1'b0;
    wt(fast_sync_n, 1'b0);
    `CHK(n inside {[6*B:7*B+8]}, 1'b1)
    read_gate_ctrl <= 1'b1;
    wt(fast_sync_n, 1'b1);
    `CHK(n inside {[6*B-4:6*B+4]}, 1'b1)
    t_tail();
  endtask : t_fixed
  task t_var;
    apb(1'b1, 12'h000, 32'h0000_0003);
    mark_search_req <= 1'b1;
    mark_detected <= 1'b1;
    wt(mark_found, 1'b1);
    wt(fast_sync_n, 1'b0);
    `CHK(n inside {[6*B-8:7*B+8]}, 1'b1)
    wt(mark_found, 1'b0);
    wt(fast_sync_n, 1'b1);
    t_tail();
    mark_detected <= 1'b0;
    mark_search_req <= 1'b0;
    apb(1'b1, 12'h000, 32'h0000_0002);
  endtask : t_var
  task t_write;
    int cnt;
    for (int i = 0; i < 4; i++)
    begin
      pat <= pt[i];
      tap <= tm[i];
      write_gate_sel_n <= 1'b0;
      repeat (200) @(posedge pclk);
      cnt = 0;
      repeat (1024)
      begin
        @(posedge pclk);
        cnt += mfm_write_pulse;
      end
      `CHK(cnt >= lo[i] && cnt <= hi[i], 1'b1)
      write_gate_sel_n <= 1'b1;
      repeat (20) @(posedge pclk);
    end
    repeat (420) @(posedge pclk);
    `CHK(no_squelch_gate, 1'b1)
  endtask : t_write
  task t_read;
    int s;
    int z;
    read_out_gate_n <= 1'b0;
    rd_on <= 1'b1;
    s = 0;
    z = 0;
    repeat (1024)
    begin
      @(posedge pclk);
      s += separated_bit;
      z += nrz_read_out;
    end
    `CHK(s > 0, 1'b1)
    `CHK(z > 0, 1'b1)
    `CHK(servo_input_select, 1'b0)
    rd_on <= 1'b0;
    read_out_gate_n <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK(nrz_read_out, 1'b0)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd[31:16], 16'h0000)
    `CHK(rd[15:0] > 16'h0010, 1'b1)
  endtask : t_read
  // main sequence
  initial
  begin
    {psel, penable, pwrite, seek_done, return_to_zero} = '0;
    {mark_detected, mark_search_req, rd_on, presetn} = '0;
    {write_gate_sel_n, read_gate_ctrl, read_out_gate_n} = 3'h7;
    {paddr, pwdata, ph, tap, pat} = '0;
    n_mismatch = 0;
    compares = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    t_regs();
    t_start();
    t_fixed();
    t_var();
    t_write();
    t_read();
    return_to_zero <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK(loop_squelch_n, 1'b0)
    end_sim();
  end
  // hang guard
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end
endmodule : mfm_codec_vfo_sequencer_test
bind mfm_codec_vfo_sequencer mfm_chk mfm_chk_inst (.*);
`default_nettype wire

// *** mfm_host_model.sv ***
/*
  Controller model: serial write data with its clock, 16 pclk per bit.
  Assumes the bench picks the pattern and shares the reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mfm_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] pat,
  output logic            host_write_clock,
  output logic            nrz_write_in
);
  logic [3:0] c_q; // bit phase
  logic       t_q; // alternating bit
  // clock rises at bit start, data moves mid-low
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      c_q <= '0;
      t_q <= 1'b0;
      host_write_clock <= 1'b0;
      nrz_write_in <= 1'b0;
    end
    else
    begin
      c_q <= c_q + 4'h1;
      host_write_clock <= ~c_q[3];
      if (c_q == 4'hB)
      begin
        t_q <= ~t_q;
        nrz_write_in <= pat[0] | (pat[1] & t_q);
      end
    end
endmodule : mfm_host_model
`default_nettype wire

// *** pin_sync.sv ***
/*
  Three-flop pin synchroniser with level and edge pulses.
  Assumes pins are asynchronous to pclk; outputs are pclk-synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire  logic         pclk,
  input  wire  logic         presetn,
  input  wire  logic [W-1:0] din,
  output logic       [W-1:0] level,
  output logic       [W-1:0] rise,
  output logic       [W-1:0] fall
);

  // per-pin three flops and qualified level
  for (genvar i = 0; i < W; i++)
  begin : g_pin
    logic s1_q;  // first stage, read only by s2
    logic s2_q;  // second stage
    logic s3_q;  // third stage

    // shift chain
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
      end
      else
      begin
        s1_q <= din[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end

    // change accepted once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        level[i] <= 1'b0;
        rise[i]  <= 1'b0;
        fall[i]  <= 1'b0;
      end
      else
      begin
        rise[i] <= (s2_q == s3_q) && s3_q && !level[i];
        fall[i] <= (s2_q == s3_q) && !s3_q && level[i];
        if (s2_q == s3_q)
          level[i] <= s3_q;
      end
    end
  end

endmodule : pin_sync
`default_nettype wire
